//--- hw/cfb_pkg.sv
package cfb_pkg;
  // ********************************************************
  // register offsets, one aligned word each
  // ********************************************************
  localparam logic [5:0] OFS_IP    = 6'h00;
  localparam logic [5:0] OFS_ACC   = 6'h04;
  localparam logic [5:0] OFS_TACC  = 6'h08;
  localparam logic [5:0] OFS_IX    = 6'h0C;
  localparam logic [5:0] OFS_EP    = 6'h10;
  localparam logic [5:0] OFS_SP    = 6'h14;
  localparam logic [5:0] OFS_PS    = 6'h18;
  localparam logic [5:0] OFS_OP    = 6'h1C;
  localparam logic [5:0] OFS_GPR   = 6'h20;
  localparam logic [5:0] OFS_PROBE = 6'h24;
  localparam logic [5:0] OFS_INT   = 6'h28;
  // ********************************************************
  // field positions
  // ********************************************************
  localparam int FL_C      = 0;
  localparam int FL_V      = 1;
  localparam int FL_Z      = 2;
  localparam int FL_N      = 3;
  localparam int FL_IL     = 4;
  localparam int FL_I      = 6;
  localparam int FL_H      = 7;
  localparam int BANK_LSB  = 3;
  localparam int OP_WIDE   = 8;
  // ********************************************************
  // reset values and memory map
  // ********************************************************
  localparam logic [7:0]  FLAGS_RST = 8'h30;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [15:0] GPR_BASE  = 16'h0100;
  localparam logic [15:0] IO_END    = 16'h0080;
  localparam logic [15:0] VEC_BASE  = 16'hFFC0;
  localparam logic [1:0]  IL_NONE   = 2'h3;

  typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
                            OP_SHL, OP_SHR, OP_NOP} cfb_op_t;
  typedef enum logic [1:0] {RG_IO, RG_DATA, RG_PROG, RG_VECT} cfb_region_t;

  typedef struct packed {
    logic [15:0] res;
    logic [7:0]  fl;
  } cfb_alu_t;

  typedef struct packed {
    logic [15:0] instruction_pointer;
    logic [15:0] main_accumulator;
    logic [15:0] second_operand_accumulator;
    logic [15:0] index_register;
    logic [15:0] auxiliary_pointer;
    logic [15:0] stack_top_pointer;
    logic [7:0]  bank_select_pointer;
    logic [7:0]  condition_flags_byte;
    logic [2:0]  gpr_sel;
    logic [15:0] probe;
    logic        ack;
    logic [31:0] rdata;
    logic [2:0]  irq_s1;
    logic [2:0]  irq_s2;
    logic        take;
  } cfb_state_t;
endpackage : cfb_pkg

//--- hw/cfb_core.sv
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: 16-bit instruction pointer holds next fetch address
// RL2: 16-bit main accumulator; 8-bit ops use low byte
// RL3: 16-bit second operand accumulator, low byte for 8-bit
// RL4: 16-bit index register for indexed addressing
// RL5: 16-bit auxiliary pointer used as memory address
// RL6: 16-bit stack pointer marks stack location
// RL7: status word: bank pointer high, flags low
// RL8: half-carry marks carry/borrow bit 3 to 4
// RL9: interrupt enable 1 permits; reset clears it
// RL10: level field gates; only lower level accepted
// RL11: negative flag follows result MSB
// RL12: zero flag set only on zero result
// RL13: overflow flag on two's complement overflow
// RL14: carry out of bit 7; shift-out on shifts
// RL15: 8-bit registers, eight per bank, 32 banks; only NUM_BANKS (8) populated here, higher banks wrap
// RL16: bank pointer maps registers to fixed addresses
// RL17: 64K space: I/O low, data, program top
// RL18: 8-bit operations flag the low byte only
module cfb_core #(
  parameter int          NUM_BANKS = 8,
  parameter logic [15:0] PROG_BASE = 16'hF000
) (
  input  wire logic        CLK,             // 40 MHz core clock
  input  wire logic        ARST_N,          // async reset
  input  wire logic [5:0]  AVS_ADDRESS,     // byte address
  input  wire logic        AVS_READ,        // read request
  input  wire logic        AVS_WRITE,       // write request
  input  wire logic [3:0]  AVS_BYTEENABLE,  // write lanes
  input  wire logic [31:0] AVS_WRITEDATA,   // write data
  output logic      [31:0] AVS_READDATA,    // read data
  output logic             AVS_WAITREQUEST, // stall
  input  wire logic        INT_REQ,         // interrupt request pin
  input  wire logic [1:0]  INT_LEVEL,       // request level pin
  output logic             INT_TAKE,        // request accepted
  output logic      [15:0] GPR_ADDR         // selected register address
);

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction : merge

  // banks beyond the populated ones wrap; the architecture has 32
  function automatic logic [15:0] gpr_at(input logic [7:0] bp,
                                         input logic [2:0] sel);
    logic [4:0] bank;
    bank = bp[cfb_pkg::BANK_LSB +: 5] % 5'(NUM_BANKS);     // [RL15]
    return cfb_pkg::GPR_BASE + {8'h00, bank, sel};         // [RL16]
  endfunction : gpr_at

  function automatic cfb_pkg::cfb_region_t region(input logic [15:0] a);
    if (a < cfb_pkg::IO_END)
      return cfb_pkg::RG_IO;                               // [RL17]
    else if (a < PROG_BASE)
      return cfb_pkg::RG_DATA;
    else if (a < cfb_pkg::VEC_BASE)
      return cfb_pkg::RG_PROG;
    else
      return cfb_pkg::RG_VECT;
  endfunction : region

  function automatic cfb_pkg::cfb_alu_t alu(input cfb_pkg::cfb_op_t op,
                                            input logic        wide,
                                            input logic [15:0] a,
                                            input logic [15:0] t,
                                            input logic [7:0]  fl);
    cfb_pkg::cfb_alu_t o;
    logic [15:0] ax;
    logic [15:0] tx;
    logic [16:0] s;
    logic [4:0]  hn;
    logic        am;
    logic        tm;
    logic        rm;
    // narrow ops see zero-extended low bytes only
    ax = wide ? a : {8'h00, a[7:0]};                       // [RL2] [RL18]
    tx = wide ? t : {8'h00, t[7:0]};                       // [RL3]
    s  = {1'b0, ax};
    hn = 5'h00;
    o.fl = fl;
    case (op)
      cfb_pkg::OP_ADD:
      begin
        s  = {1'b0, ax} + {1'b0, tx};
        hn = {1'b0, a[3:0]} + {1'b0, t[3:0]};
      end
      cfb_pkg::OP_SUB:
      begin
        s  = {1'b0, ax} - {1'b0, tx};
        hn = {1'b0, a[3:0]} - {1'b0, t[3:0]};
      end
      cfb_pkg::OP_AND: s = {1'b0, ax & tx};
      cfb_pkg::OP_OR:  s = {1'b0, ax | tx};
      cfb_pkg::OP_XOR: s = {1'b0, ax ^ tx};
      cfb_pkg::OP_SHL: s = {ax, 1'b0};
      cfb_pkg::OP_SHR: s = {2'b00, ax[15:1]};
      default:         s = {1'b0, ax};
    endcase
    am = wide ? ax[15] : ax[7];
    tm = wide ? tx[15] : tx[7];
    rm = wide ? s[15] : s[7];
    o.res = wide ? s[15:0] : {a[15:8], s[7:0]};
    if (op != cfb_pkg::OP_NOP)
    begin
      o.fl[cfb_pkg::FL_N] = rm;                            // [RL11]
      o.fl[cfb_pkg::FL_Z] = wide ? (s[15:0] == 16'h0000)
                                 : (s[7:0] == 8'h00);      // [RL12] [RL18]
    end
    case (op)
      cfb_pkg::OP_ADD, cfb_pkg::OP_SUB:
      begin
        o.fl[cfb_pkg::FL_H] = hn[4];                       // [RL8]
        o.fl[cfb_pkg::FL_C] = wide ? s[16] : s[8];         // [RL14]
        o.fl[cfb_pkg::FL_V] = (op == cfb_pkg::OP_ADD)
                            ? (am == tm) && (rm != am)
                            : (am != tm) && (rm != am);    // [RL13]
      end
      cfb_pkg::OP_SHL:
      begin
        o.fl[cfb_pkg::FL_C] = am;                          // [RL14]
        o.fl[cfb_pkg::FL_V] = 1'b0;
      end
      cfb_pkg::OP_SHR:
      begin
        o.fl[cfb_pkg::FL_C] = ax[0];                       // [RL14]
        o.fl[cfb_pkg::FL_V] = 1'b0;
      end
      cfb_pkg::OP_AND, cfb_pkg::OP_OR, cfb_pkg::OP_XOR:
        o.fl[cfb_pkg::FL_V] = 1'b0;
      default: o.fl = fl;
    endcase
    return o;
  endfunction : alu

  // ********************************************************
  // state
  // ********************************************************
  cfb_pkg::cfb_state_t s_q;
  cfb_pkg::cfb_state_t s_d;
  cfb_pkg::cfb_alu_t   alu_o;
  logic                req;
  logic                wr_ok;
  logic [31:0]         rd_mux;
  logic [1:0]          il_q;

  assign req   = AVS_READ | AVS_WRITE;
  // one wait cycle: read data are ready and a write lands on the ack edge
  assign wr_ok = AVS_WRITE & s_q.ack;
  assign il_q  = s_q.condition_flags_byte[cfb_pkg::FL_IL +: 2];
  assign alu_o = alu(cfb_pkg::cfb_op_t'(AVS_WRITEDATA[2:0]),
                     AVS_WRITEDATA[cfb_pkg::OP_WIDE],
                     s_q.main_accumulator,
                     s_q.second_operand_accumulator,
                     s_q.condition_flags_byte);

  always_comb
  begin
    case (AVS_ADDRESS)
      cfb_pkg::OFS_IP:    rd_mux = {16'h0000, s_q.instruction_pointer};
      cfb_pkg::OFS_ACC:   rd_mux = {16'h0000, s_q.main_accumulator};
      cfb_pkg::OFS_TACC:  rd_mux = {16'h0000, s_q.second_operand_accumulator};
      cfb_pkg::OFS_IX:    rd_mux = {16'h0000, s_q.index_register};
      cfb_pkg::OFS_EP:    rd_mux = {16'h0000, s_q.auxiliary_pointer};
      cfb_pkg::OFS_SP:    rd_mux = {16'h0000, s_q.stack_top_pointer};
      cfb_pkg::OFS_PS:    rd_mux = {16'h0000, s_q.bank_select_pointer,
                                    s_q.condition_flags_byte};  // [RL7]
      cfb_pkg::OFS_GPR:   rd_mux = {13'h0000, s_q.gpr_sel,
                                    gpr_at(s_q.bank_select_pointer,
                                           s_q.gpr_sel)};
      cfb_pkg::OFS_PROBE: rd_mux = {14'h0000, region(s_q.probe), s_q.probe};
      cfb_pkg::OFS_INT:   rd_mux = {31'h00000000, s_q.take};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  always_comb
  begin
    logic [31:0] m;
    m = 32'h00000000;
    s_d = s_q;
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack)
      s_d.rdata = rd_mux;
    // level pins cross in on two flops before anything reads them
    s_d.irq_s1 = {INT_REQ, INT_LEVEL};
    s_d.irq_s2 = s_q.irq_s1;
    s_d.take = s_q.irq_s2[2]
             & s_q.condition_flags_byte[cfb_pkg::FL_I]     // [RL9]
             & (il_q != cfb_pkg::IL_NONE)
             & (s_q.irq_s2[1:0] < il_q);                   // [RL10]
    if (wr_ok)
    begin
      case (AVS_ADDRESS)
        cfb_pkg::OFS_IP:
        begin
          m = merge({16'h0000, s_q.instruction_pointer}, AVS_WRITEDATA,
                    AVS_BYTEENABLE);
          s_d.instruction_pointer = m[15:0];               // [RL1]
        end
        cfb_pkg::OFS_ACC:
        begin
          m = merge({16'h0000, s_q.main_accumulator}, AVS_WRITEDATA,
                    AVS_BYTEENABLE);
          s_d.main_accumulator = m[15:0];                  // [RL2]
        end
        cfb_pkg::OFS_TACC:
        begin
          m = merge({16'h0000, s_q.second_operand_accumulator},
                    AVS_WRITEDATA, AVS_BYTEENABLE);
          s_d.second_operand_accumulator = m[15:0];        // [RL3]
        end
        cfb_pkg::OFS_IX:
        begin
          m = merge({16'h0000, s_q.index_register}, AVS_WRITEDATA,
                    AVS_BYTEENABLE);
          s_d.index_register = m[15:0];                    // [RL4]
        end
        cfb_pkg::OFS_EP:
        begin
          m = merge({16'h0000, s_q.auxiliary_pointer}, AVS_WRITEDATA,
                    AVS_BYTEENABLE);
          s_d.auxiliary_pointer = m[15:0];                 // [RL5]
        end
        cfb_pkg::OFS_SP:
        begin
          m = merge({16'h0000, s_q.stack_top_pointer}, AVS_WRITEDATA,
                    AVS_BYTEENABLE);
          s_d.stack_top_pointer = m[15:0];                 // [RL6]
        end
        cfb_pkg::OFS_PS:
        begin
          m = merge({16'h0000, s_q.bank_select_pointer,
                     s_q.condition_flags_byte}, AVS_WRITEDATA,
                    AVS_BYTEENABLE);
          s_d.bank_select_pointer  = m[15:8];              // [RL7]
          s_d.condition_flags_byte = m[7:0];
        end
        cfb_pkg::OFS_OP:
        begin
          // an operation needs the low byte lane; others are ignored
          if (AVS_BYTEENABLE[0])
          begin
            s_d.main_accumulator     = alu_o.res;          // [RL2]
            s_d.condition_flags_byte = alu_o.fl;
          end
        end
        cfb_pkg::OFS_GPR:
          if (AVS_BYTEENABLE[0])
            s_d.gpr_sel = AVS_WRITEDATA[2:0];
        cfb_pkg::OFS_PROBE:
        begin
          m = merge({16'h0000, s_q.probe}, AVS_WRITEDATA, AVS_BYTEENABLE);
          s_d.probe = m[15:0];
        end
        default: m = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_q <= '0;
      s_q.condition_flags_byte <= cfb_pkg::FLAGS_RST;      // [RL9]
      s_q.instruction_pointer  <= cfb_pkg::WORD_RST;
    end
    else
      s_q <= s_d;
  end

  assign AVS_WAITREQUEST = req & ~s_q.ack;
  assign AVS_READDATA    = s_q.rdata;
  assign INT_TAKE        = s_q.take;
  assign GPR_ADDR        = gpr_at(s_q.bank_select_pointer, s_q.gpr_sel);

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_op(logic [2:0] code, logic wide);
    wr_ok && AVS_ADDRESS == cfb_pkg::OFS_OP && AVS_BYTEENABLE[0]
      && AVS_WRITEDATA[2:0] == code && AVS_WRITEDATA[cfb_pkg::OP_WIDE] == wide;
  endsequence

  a_ip_write_lands: assert property (wr_ok && AVS_ADDRESS == cfb_pkg::OFS_IP // [RL1]
      && AVS_BYTEENABLE == 4'hF |=> s_q.instruction_pointer == $past(AVS_WRITEDATA[15:0]))
    else $error("instruction pointer write lost");
  a_wait_one_cycle: assert property ($rose(req) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) // Avalon-MM wait cycle, chosen here
    else $error("bus answer not after one wait cycle");
  a_zero_low_byte: assert property (s_op(3'h0, 1'b0) |=> // [RL12]
      s_q.condition_flags_byte[cfb_pkg::FL_Z] == (s_q.main_accumulator[7:0] == 8'h00))
    else $error("zero flag wrong for 8-bit add");
  a_neg_msb_wide: assert property (s_op(3'h1, 1'b1) |=> // [RL11]
      s_q.condition_flags_byte[cfb_pkg::FL_N] == s_q.main_accumulator[15])
    else $error("negative flag wrong for 16-bit subtract");
  a_narrow_keeps_high: assert property (s_op(3'h0, 1'b0) |=> // [RL18]
      s_q.main_accumulator[15:8] == $past(s_q.main_accumulator[15:8]))
    else $error("8-bit op touched high byte");
  a_shift_out_carry: assert property (s_op(3'h6, 1'b0) |=> // [RL14]
      s_q.condition_flags_byte[cfb_pkg::FL_C] == $past(s_q.main_accumulator[0]))
    else $error("shift carry wrong");
  a_half_carry_add: assert property (s_op(3'h0, 1'b0) |=> // [RL8]
      s_q.condition_flags_byte[cfb_pkg::FL_H] == (({1'b0, $past(s_q.main_accumulator[3:0])}
      + {1'b0, $past(s_q.second_operand_accumulator[3:0])}) > 5'h0F))
    else $error("half carry wrong");
  a_take_gated: assert property (INT_TAKE |-> $past(s_q.condition_flags_byte[cfb_pkg::FL_I]) // [RL9]
      && $past(il_q) != cfb_pkg::IL_NONE && $past(s_q.irq_s2[1:0]) < $past(il_q))
    else $error("interrupt taken while gated");
  a_bank_in_range: assert property (GPR_ADDR - cfb_pkg::GPR_BASE < 16'(8 * NUM_BANKS)) // [RL15]
    else $error("register address outside populated banks");
  a_io_region_low: assert property (AVS_READ && !AVS_WAITREQUEST // [RL17]
      && AVS_ADDRESS == cfb_pkg::OFS_PROBE && s_q.probe < cfb_pkg::IO_END
      |-> AVS_READDATA[17:16] == 2'(cfb_pkg::RG_IO))
    else $error("low address not read back as i/o area");

endmodule : cfb_core

//--- test/cfb_core_tb_top.sv
`timescale 1ns/1ps
module cfb_core_tb_top;
  typedef struct packed {
    logic [2:0]  op;
    logic        wide;
    logic [15:0] a;
    logic [15:0] t;
    logic [7:0]  fin;
    logic [15:0] ares;
    logic [7:0]  fres;
  } cfb_tb_alu_t;

  logic        clk;
  logic        arst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        int_req;
  logic [1:0]  int_level;
  logic        int_take;
  logic [15:0] gpr_addr;
  int          failures;
  int          check_count;
  logic [31:0] scratch;
  cfb_tb_alu_t alu_tab [13];
  logic [11:0] int_tab [7];
  logic [17:0] probe_tab [8];
  logic [26:0] bank_tab [4];

  cfb_core #(
    .NUM_BANKS (8),
    .PROG_BASE (16'hF000)
  ) cfb_core_i (
    .CLK             (clk),
    .ARST_N          (arst_n),
    .AVS_ADDRESS     (avs_address),
    .AVS_READ        (avs_read),
    .AVS_WRITE       (avs_write),
    .AVS_BYTEENABLE  (avs_byteenable),
    .AVS_WRITEDATA   (avs_writedata),
    .AVS_READDATA    (avs_readdata),
    .AVS_WAITREQUEST (avs_waitrequest),
    .INT_REQ         (int_req),
    .INT_LEVEL       (int_level),
    .INT_TAKE        (int_take),
    .GPR_ADDR        (gpr_addr)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ********************************************************
  // reporting and bus tasks
  // ********************************************************
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic complete_run;
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // an idle edge first, so a release and the next raise never share a time step
  task automatic bus_access(input logic wr, input logic [5:0] addr, input logic [31:0] wdata,
                            input logic [3:0] be, output logic [31:0] rdata);
    int   waits;
    logic stall;
    waits = 0;
    stall = 1'b1;
    @(posedge clk);
    avs_address    <= addr;
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= wdata;
    avs_byteenable <= be;
    while (stall !== 1'b0)
    begin
      // read before this edge's updates land, so these are the sampled values
      @(posedge clk);
      stall = avs_waitrequest;
      if (stall === 1'b0)
        rdata = avs_readdata;
      else
        waits++;
      if (waits > 20)
      begin
        failures++;
        complete_run();
      end
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    check_word("wait states", 32'h1, waits);
  endtask : bus_access

  task automatic reg_write(input logic [5:0] addr, input logic [31:0] data);
    logic [31:0] dummy;
    bus_access(1'b1, addr, data, 4'hF, dummy);
  endtask : reg_write

  task automatic reg_check(input string what, input logic [5:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus_access(1'b0, addr, 32'h0, 4'h0, got);
    check_word(what, exp, got);
  endtask : reg_check

  task automatic apply_reset;
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
  endtask : apply_reset

  task automatic check_reset_values;
    logic [5:0] ofs [7];
    ofs = '{cfb_pkg::OFS_IP, cfb_pkg::OFS_ACC, cfb_pkg::OFS_TACC, cfb_pkg::OFS_IX,
            cfb_pkg::OFS_EP, cfb_pkg::OFS_SP, cfb_pkg::OFS_PS};
    for (int i = 0; i < 7; i++)
      reg_check("reset value", ofs[i], (i == 6) ? 32'h30 : 32'h0);
    check_word("gpr addr port", 32'h0100, {16'h0, gpr_addr});
  endtask : check_reset_values

  // ********************************************************
  // main sequence
  // ********************************************************
  initial
  begin
    arst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    int_req = 1'b0;
    int_level = 2'h0;
    failures = 0;
    check_count = 0;
    alu_tab = '{'{3'h0, 1'b0, 16'h120F, 16'h0001, 8'h30, 16'h1210, 8'hB0},
                '{3'h0, 1'b0, 16'h007F, 16'h0001, 8'h30, 16'h0080, 8'hBA},
                '{3'h0, 1'b0, 16'hAAFF, 16'h0001, 8'h30, 16'hAA00, 8'hB5},
                '{3'h1, 1'b0, 16'h0000, 16'h0001, 8'h30, 16'h00FF, 8'hB9},
                '{3'h0, 1'b1, 16'h8000, 16'h8000, 8'h30, 16'h0000, 8'h37},
                '{3'h0, 1'b1, 16'h0FFF, 16'h0001, 8'h30, 16'h1000, 8'hB0},
                '{3'h5, 1'b0, 16'h0081, 16'h0001, 8'hB0, 16'h0002, 8'hB1},
                '{3'h6, 1'b0, 16'h0001, 16'h0001, 8'h30, 16'h0000, 8'h35},
                '{3'h2, 1'b0, 16'h00F0, 16'h000F, 8'h33, 16'h0000, 8'h35},
                '{3'h3, 1'b0, 16'h0080, 16'h0000, 8'h30, 16'h0080, 8'h38},
                '{3'h4, 1'b0, 16'h00FF, 16'h00FF, 8'h30, 16'h0000, 8'h34},
                '{3'h7, 1'b0, 16'h1234, 16'h0001, 8'h3A, 16'h1234, 8'h3A},
                '{3'h1, 1'b1, 16'h0000, 16'h0001, 8'h30, 16'hFFFF, 8'hB9}};
    // first entry: enable flag clear blocks a request the level would pass
    int_tab = '{12'h820, 12'hAC1, 12'hCC0, 12'h8E0, 12'h880, 12'h8A1, 12'h0C0};
    probe_tab = '{18'h00000, 18'h0007F, 18'h10080, 18'h1EFFF,
                  18'h2F000, 18'h2FFBF, 18'h3FFC0, 18'h3FFFF};
    bank_tab = '{{8'h08, 3'h3, 16'h010B}, {8'h38, 3'h7, 16'h013F},
                 {8'h40, 3'h0, 16'h0100}, {8'hF8, 3'h5, 16'h013D}};
    @(posedge clk);
    apply_reset();
    check_reset_values();
    for (int i = 0; i < 7; i++)
    begin
      reg_write(6'(4 * i), {16'hFFFF, 16'hA5C3 ^ 16'(i)});
      reg_check("register word", 6'(4 * i), {16'h0, 16'hA5C3 ^ 16'(i)});
    end
    bus_access(1'b1, cfb_pkg::OFS_IX, 32'h000012AB, 4'h1, scratch);
    reg_check("index lane merge", cfb_pkg::OFS_IX, 32'h0000A5AB);
    reg_write(6'h2C, 32'hFFFFFFFF);
    reg_check("unmapped read", 6'h2C, 32'h0);
    reg_write(cfb_pkg::OFS_ACC, 32'h0001);
    bus_access(1'b1, cfb_pkg::OFS_OP, 32'h0, 4'h2, scratch);
    reg_check("op lane ignored", cfb_pkg::OFS_ACC, 32'h0001);
    for (int i = 0; i < 13; i++)
    begin
      reg_write(cfb_pkg::OFS_PS, {24'h0, alu_tab[i].fin});
      reg_write(cfb_pkg::OFS_ACC, {16'h0, alu_tab[i].a});
      reg_write(cfb_pkg::OFS_TACC, {16'h0, alu_tab[i].t});
      reg_write(cfb_pkg::OFS_OP, {23'h0, alu_tab[i].wide, 5'h0, alu_tab[i].op});
      reg_check("alu result", cfb_pkg::OFS_ACC, {16'h0, alu_tab[i].ares});
      reg_check("alu flags", cfb_pkg::OFS_PS, {24'h0, alu_tab[i].fres});
    end
    for (int i = 0; i < 4; i++)
    begin
      reg_write(cfb_pkg::OFS_PS, {16'h0, bank_tab[i][26:19], 8'h30});
      reg_write(cfb_pkg::OFS_GPR, {29'h0, bank_tab[i][18:16]});
      reg_check("gpr select", cfb_pkg::OFS_GPR, {13'h0, bank_tab[i][18:0]});
      check_word("gpr addr port", {16'h0, bank_tab[i][15:0]}, {16'h0, gpr_addr});
    end
    for (int i = 0; i < 8; i++)
    begin
      reg_write(cfb_pkg::OFS_PROBE, {16'h0, probe_tab[i][15:0]});
      reg_check("probe region", cfb_pkg::OFS_PROBE, {14'h0, probe_tab[i]});
    end
    for (int i = 0; i < 7; i++)
    begin
      int_req   <= int_tab[i][11];
      int_level <= int_tab[i][10:9];
      reg_write(cfb_pkg::OFS_PS, {24'h0, int_tab[i][8:1]});
      repeat (4) @(posedge clk);
      check_word("int take pin", {31'h0, int_tab[i][0]}, {31'h0, int_take});
      reg_check("int register", cfb_pkg::OFS_INT, {31'h0, int_tab[i][0]});
    end
    int_req <= 1'b0;
    reg_write(cfb_pkg::OFS_ACC, 32'h5555);
    reg_write(cfb_pkg::OFS_PS, 32'h48F0);
    apply_reset();
    check_reset_values();
    complete_run();
  end
endmodule : cfb_core_tb_top
